// [design/dur_chan.sv]
// One channel: ready handshakes, loopback routing and clear-to-send sampling.
// Assumes FIFO status inputs synchronous to ref_clk_i.
`timescale 1ns/1ps
`default_nettype none
module dur_chan
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire dur_pkg::dur_chan_cfg_t cfg_i,
   input wire dur_pkg::dur_fifo_stat_t fifo_i,
   input wire logic clear_to_send_n_i,
   input wire logic rx_serial_pin_i,
   input wire logic tx_serial_core_i,
   output logic rx_ready_n_o,
   output logic tx_ready_n_o,
   output logic serial_out_o,
   output logic rx_serial_core_o,
   output logic tx_allow_o,
   output logic cts_active_o,
   output logic [dur_pkg::DUR_EV_W-1:0] events_o
);
   logic rx_rdy;
   logic next_rx_rdy;
   logic tx_rdy;
   logic next_tx_rdy;
   logic cts_q;
   logic next_cts_q;
   logic ser_out;
   logic next_ser_out;
   logic rx_core;
   logic next_rx_core;

   always_comb
   begin
      next_rx_rdy = rx_rdy;
      if (fifo_i.rx_count == 7'h00 || fifo_i.rx_error)
         next_rx_rdy = 1'b0;
      else if (fifo_i.rx_count >= cfg_i.rx_trig || fifo_i.rx_timeout)
         next_rx_rdy = 1'b1;
      next_tx_rdy = tx_rdy;
      if (fifo_i.tx_full)
         next_tx_rdy = 1'b0;
      else if (fifo_i.tx_free >= cfg_i.tx_trig)
         next_tx_rdy = 1'b1;
      next_cts_q = ~clear_to_send_n_i;
      next_ser_out = cfg_i.loopback ? 1'b1 : tx_serial_core_i;
      next_rx_core = cfg_i.loopback ? tx_serial_core_i : rx_serial_pin_i;
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rx_rdy <= 1'b0;
         tx_rdy <= 1'b0;
         cts_q <= 1'b0;
         ser_out <= 1'b1;
         rx_core <= 1'b1;
      end
      else if (ce_i)
      begin
         rx_rdy <= next_rx_rdy;
         tx_rdy <= next_tx_rdy;
         cts_q <= next_cts_q;
         ser_out <= next_ser_out;
         rx_core <= next_rx_core;
      end
   end

   always_comb
   begin
      events_o = '0;
      events_o[dur_pkg::DUR_EV_RX_READY] = ce_i & next_rx_rdy & ~rx_rdy;
      events_o[dur_pkg::DUR_EV_TX_READY] = ce_i & next_tx_rdy & ~tx_rdy;
      events_o[dur_pkg::DUR_EV_CTS_CHANGE] = ce_i & (next_cts_q ^ cts_q);
      events_o[dur_pkg::DUR_EV_RX_ERROR] = ce_i & fifo_i.rx_error;
   end

   assign rx_ready_n_o = ~rx_rdy;
   assign tx_ready_n_o = ~tx_rdy;
   assign serial_out_o = ser_out;
   assign rx_serial_core_o = rx_core;
   assign cts_active_o = cts_q;
   assign tx_allow_o = ~cfg_i.auto_cts | cts_q;
endmodule
`default_nettype wire

// [design/dur_pkg.sv]
// Shared constants and carriers for the two-channel UART host handshake block.
// Assumes a 32-bit APB register bus with one aligned word per register.
package dur_pkg;
   localparam int unsigned DUR_CHANS = 2;
   localparam int unsigned DUR_CNT_W = 7;
   localparam int unsigned DUR_DATA_W = 32;
   localparam int unsigned DUR_IDX_LSB = 2;
   localparam int unsigned DUR_IDX_MSB = 4;
   localparam int unsigned DUR_CHAN_BIT = 5;
   localparam int unsigned DUR_MAP_TOP = 6;
   localparam logic [2:0] DUR_IDX_RX_TRIG = 3'h0;
   localparam logic [2:0] DUR_IDX_TX_TRIG = 3'h1;
   localparam logic [2:0] DUR_IDX_EFR = 3'h2;
   localparam logic [2:0] DUR_IDX_MCR = 3'h3;
   localparam logic [2:0] DUR_IDX_MSR = 3'h4;
   localparam logic [2:0] DUR_IDX_LEVEL = 3'h5;
   localparam logic [2:0] DUR_IDX_INT_STAT = 3'h6;
   localparam logic [2:0] DUR_IDX_INT_MASK = 3'h7;
   localparam int unsigned DUR_MCR_RTS_BIT = 1;
   localparam int unsigned DUR_MCR_LOOP_BIT = 4;
   localparam int unsigned DUR_MSR_CTS_BIT = 4;
   localparam int unsigned DUR_EFR_AUTO_CTS_BIT = 7;
   localparam int unsigned DUR_LEVEL_TX_LSB = 8;
   localparam int unsigned DUR_LEVEL_ERR_BIT = 16;
   localparam int unsigned DUR_EV_W = 4;
   localparam int unsigned DUR_EV_RX_READY = 0;
   localparam int unsigned DUR_EV_TX_READY = 1;
   localparam int unsigned DUR_EV_CTS_CHANGE = 2;
   localparam int unsigned DUR_EV_RX_ERROR = 3;
   localparam logic [6:0] DUR_RX_TRIG_RST = 7'h01;
   localparam logic [6:0] DUR_TX_TRIG_RST = 7'h01;
   localparam logic [7:0] DUR_EFR_RST = 8'h00;
   localparam logic [7:0] DUR_MCR_RST = 8'h00;
   localparam logic [3:0] DUR_INT_STAT_RST = 4'h0;
   localparam logic [3:0] DUR_INT_MASK_RST = 4'h0;

   typedef struct packed {
      logic [6:0] rx_trig;
      logic [6:0] tx_trig;
      logic auto_cts;
      logic loopback;
   } dur_chan_cfg_t;

   typedef struct packed {
      logic [6:0] rx_count;
      logic rx_timeout;
      logic rx_error;
      logic [6:0] tx_free;
      logic tx_full;
   } dur_fifo_stat_t;
endpackage

// [design/dur_rst_sync.sv]
// Reset release synchroniser.
// Assumes an active-low asynchronous reset at the input.
`timescale 1ns/1ps
`default_nettype none
module dur_rst_sync
(
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   output logic rst_n_o
);
   logic stage1;
   logic stage2;

   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         stage1 <= 1'b0;
         stage2 <= 1'b0;
      end
      else
      begin
         stage1 <= 1'b1;
         stage2 <= stage1;
      end
   end

   assign rst_n_o = stage2;
endmodule
`default_nettype wire

// [design/dur_top.sv]
// Two-channel UART host handshake block with an APB register slave.
// Assumes APB master synchronous to ref_clk_i and FIFO status from the UART cores.
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dur_top
#(
   parameter int unsigned ADDR_W = 12
)
(
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq_o,
   input wire dur_pkg::dur_fifo_stat_t fifo_chan_a_i,
   input wire dur_pkg::dur_fifo_stat_t fifo_chan_b_i,
   input wire logic clear_to_send_n_chan_a_i,
   input wire logic clear_to_send_n_chan_b_i,
   input wire logic rx_serial_chan_a_i,
   input wire logic rx_serial_chan_b_i,
   input wire logic tx_serial_core_chan_a_i,
   input wire logic tx_serial_core_chan_b_i,
   output logic rx_ready_n_chan_a_o,
   output logic rx_ready_n_chan_b_o,
   output logic tx_ready_n_chan_a_o,
   output logic tx_ready_n_chan_b_o,
   output logic serial_out_chan_a_o,
   output logic serial_out_chan_b_o,
   output logic rx_serial_core_chan_a_o,
   output logic rx_serial_core_chan_b_o,
   output logic tx_allow_chan_a_o,
   output logic tx_allow_chan_b_o,
   output logic request_to_send_n_chan_a_o,
   output logic request_to_send_n_chan_b_o
);
   localparam int unsigned NCH = dur_pkg::DUR_CHANS;
   localparam int unsigned EVW = dur_pkg::DUR_EV_W;

   logic rst_n;
   logic in_map;
   logic setup;
   logic wr_access;
   logic [2:0] reg_addr;
   logic [NCH-1:0] select_n;
   logic [31:0] next_prdata;
   logic [31:0] rd_word [NCH];
   dur_pkg::dur_fifo_stat_t fifo [NCH];
   dur_pkg::dur_chan_cfg_t cfg [NCH];
   logic [NCH-1:0] cts_n;
   logic [NCH-1:0] rx_pin;
   logic [NCH-1:0] tx_core;
   logic [NCH-1:0] rx_ready_n;
   logic [NCH-1:0] tx_ready_n;
   logic [NCH-1:0] ser_out;
   logic [NCH-1:0] rx_core;
   logic [NCH-1:0] tx_allow;
   logic [NCH-1:0] cts_active;
   logic [NCH-1:0] rts_n;
   logic [NCH-1:0] irq_chan;
   logic [EVW-1:0] events [NCH];
   logic [6:0] rx_trig [NCH];
   logic [6:0] tx_trig [NCH];
   logic [7:0] enhanced_feature_register [NCH];
   logic [7:0] modem_control_register [NCH];
   logic [EVW-1:0] int_stat [NCH];
   logic [EVW-1:0] int_mask [NCH];

   // All checks run on the block clock and pause during reset
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n);

   dur_rst_sync u_rst_sync
   (
      .ref_clk_i(ref_clk_i),
      .reset_n_i(reset_n_i),
      .rst_n_o(rst_n)
   );

   assign fifo[0] = fifo_chan_a_i;
   assign fifo[1] = fifo_chan_b_i;
   assign cts_n = {clear_to_send_n_chan_b_i, clear_to_send_n_chan_a_i};
   assign rx_pin = {rx_serial_chan_b_i, rx_serial_chan_a_i};
   assign tx_core = {tx_serial_core_chan_b_i, tx_serial_core_chan_a_i};

   // Address decode: word index and channel select
   assign reg_addr = paddr[dur_pkg::DUR_IDX_MSB:dur_pkg::DUR_IDX_LSB];
   assign in_map = (paddr >> dur_pkg::DUR_MAP_TOP) == '0;
   assign setup = psel & ~penable;
   assign wr_access = psel & penable & pwrite & in_map;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~in_map;

   genvar c;
   generate
      for (c = 0; c < NCH; c++)
      begin : g_chan
         logic [6:0] next_rx_trig;
         logic [6:0] next_tx_trig;
         logic [7:0] next_efr;
         logic [7:0] next_mcr;
         logic [EVW-1:0] next_int_stat;
         logic [EVW-1:0] next_int_mask;
         logic next_rts_n;
         logic hit;

         // Channel select derived from the channel address bit
         assign select_n[c] = ~(psel & in_map &
            (paddr[dur_pkg::DUR_CHAN_BIT] == 1'(c)));

         always_comb
         begin
            hit = wr_access & ~select_n[c];
            next_rx_trig = rx_trig[c];
            next_tx_trig = tx_trig[c];
            next_efr = enhanced_feature_register[c];
            next_mcr = modem_control_register[c];
            next_int_mask = int_mask[c];
            next_int_stat = int_stat[c];
            if (hit)
            begin
               case (reg_addr)
                  dur_pkg::DUR_IDX_RX_TRIG: next_rx_trig = pwdata[6:0];
                  dur_pkg::DUR_IDX_TX_TRIG: next_tx_trig = pwdata[6:0];
                  dur_pkg::DUR_IDX_EFR: next_efr = pwdata[7:0];
                  dur_pkg::DUR_IDX_MCR: next_mcr = pwdata[7:0];
                  dur_pkg::DUR_IDX_INT_MASK: next_int_mask = pwdata[EVW-1:0];
                  dur_pkg::DUR_IDX_INT_STAT: next_int_stat = int_stat[c] & ~pwdata[EVW-1:0];
                  default: next_rx_trig = rx_trig[c];
               endcase
            end
            // A new event outweighs a simultaneous clear
            next_int_stat = next_int_stat | events[c];
            next_rts_n = ~modem_control_register[c][dur_pkg::DUR_MCR_RTS_BIT];
         end

         always_ff @(posedge ref_clk_i or negedge rst_n)
         begin
            if (!rst_n)
            begin
               rx_trig[c] <= dur_pkg::DUR_RX_TRIG_RST;
               tx_trig[c] <= dur_pkg::DUR_TX_TRIG_RST;
               enhanced_feature_register[c] <= dur_pkg::DUR_EFR_RST;
               modem_control_register[c] <= dur_pkg::DUR_MCR_RST;
               int_stat[c] <= dur_pkg::DUR_INT_STAT_RST;
               int_mask[c] <= dur_pkg::DUR_INT_MASK_RST;
               rts_n[c] <= 1'b1;
            end
            else if (ce_i)
            begin
               rx_trig[c] <= next_rx_trig;
               tx_trig[c] <= next_tx_trig;
               enhanced_feature_register[c] <= next_efr;
               modem_control_register[c] <= next_mcr;
               int_stat[c] <= next_int_stat;
               int_mask[c] <= next_int_mask;
               rts_n[c] <= next_rts_n;
            end
         end

         always_comb
         begin
            cfg[c].rx_trig = rx_trig[c];
            cfg[c].tx_trig = tx_trig[c];
            cfg[c].auto_cts = enhanced_feature_register[c][dur_pkg::DUR_EFR_AUTO_CTS_BIT];
            cfg[c].loopback = modem_control_register[c][dur_pkg::DUR_MCR_LOOP_BIT];
         end

         always_comb
         begin
            rd_word[c] = 32'h0000_0000;
            case (reg_addr)
               dur_pkg::DUR_IDX_RX_TRIG: rd_word[c][6:0] = rx_trig[c];
               dur_pkg::DUR_IDX_TX_TRIG: rd_word[c][6:0] = tx_trig[c];
               dur_pkg::DUR_IDX_EFR: rd_word[c][7:0] = enhanced_feature_register[c];
               dur_pkg::DUR_IDX_MCR: rd_word[c][7:0] = modem_control_register[c];
               dur_pkg::DUR_IDX_MSR: rd_word[c][dur_pkg::DUR_MSR_CTS_BIT] = cts_active[c];
               dur_pkg::DUR_IDX_LEVEL:
               begin
                  rd_word[c][6:0] = fifo[c].rx_count;
                  rd_word[c][dur_pkg::DUR_LEVEL_TX_LSB +: 7] = fifo[c].tx_free;
                  rd_word[c][dur_pkg::DUR_LEVEL_ERR_BIT] = fifo[c].rx_error;
               end
               dur_pkg::DUR_IDX_INT_STAT: rd_word[c][EVW-1:0] = int_stat[c];
               dur_pkg::DUR_IDX_INT_MASK: rd_word[c][EVW-1:0] = int_mask[c];
               default: rd_word[c] = 32'h0000_0000;
            endcase
         end

         // Independent channel instance
         dur_chan u_chan
         (
            .ref_clk_i(ref_clk_i),
            .rst_n_i(rst_n),
            .ce_i(ce_i),
            .cfg_i(cfg[c]),
            .fifo_i(fifo[c]),
            .clear_to_send_n_i(cts_n[c]),
            .rx_serial_pin_i(rx_pin[c]),
            .tx_serial_core_i(tx_core[c]),
            .rx_ready_n_o(rx_ready_n[c]),
            .tx_ready_n_o(tx_ready_n[c]),
            .serial_out_o(ser_out[c]),
            .rx_serial_core_o(rx_core[c]),
            .tx_allow_o(tx_allow[c]),
            .cts_active_o(cts_active[c]),
            .events_o(events[c])
         );

         assign irq_chan[c] = |(int_stat[c] & int_mask[c]);

         // Per-channel handshake checks
         sequence rx_hit_s;
            ce_i && fifo[c].rx_count != 7'h00 && !fifo[c].rx_error &&
               (fifo[c].rx_count >= rx_trig[c] || fifo[c].rx_timeout);
         endsequence

         sequence rx_drop_s;
            ce_i && (fifo[c].rx_count == 7'h00 || fifo[c].rx_error);
         endsequence

         rx_ready_low_a: assert property (rx_hit_s |=> !rx_ready_n[c])
            else $error("receive ready not asserted at trigger");
         rx_ready_high_a: assert property (rx_drop_s |=> rx_ready_n[c])
            else $error("receive ready not released on empty or error");
         tx_ready_low_a: assert property (ce_i && !fifo[c].tx_full &&
            fifo[c].tx_free >= tx_trig[c] |=> !tx_ready_n[c])
            else $error("transmit ready not asserted at trigger");
         tx_full_high_a: assert property (ce_i && fifo[c].tx_full |=> tx_ready_n[c])
            else $error("transmit ready low while buffer full");
         rx_hold_a: assert property (ce_i && fifo[c].rx_count != 7'h00 &&
            !fifo[c].rx_error && fifo[c].rx_count < rx_trig[c] && !fifo[c].rx_timeout
            |=> $stable(rx_ready_n[c])) else $error("receive ready moved between thresholds");
         tx_hold_a: assert property (ce_i && !fifo[c].tx_full &&
            fifo[c].tx_free < tx_trig[c] |=> $stable(tx_ready_n[c]))
            else $error("transmit ready moved below trigger");
         loop_route_a: assert property (ce_i && cfg[c].loopback |=>
            ser_out[c] && rx_core[c] == $past(tx_core[c]))
            else $error("loopback routing wrong");
         reg_decode_a: assert property (ce_i && wr_access && !select_n[c] &&
            reg_addr == dur_pkg::DUR_IDX_RX_TRIG |=> rx_trig[c] == $past(pwdata[6:0]))
            else $error("trigger register write misdecoded");
         unselected_a: assert property (ce_i && select_n[c] |=>
            $stable(modem_control_register[c]) && $stable(enhanced_feature_register[c]) && $stable(rx_trig[c]))
            else $error("unselected channel register changed");
         msr_cts_a: assert property ($past(ce_i) |->
            cts_active[c] == !$past(cts_n[c]))
            else $error("clear-to-send status does not follow pin");
         auto_cts_a: assert property ($past(ce_i) |->
            tx_allow[c] == (!cfg[c].auto_cts || !$past(cts_n[c])))
            else $error("transmit permission does not follow flow control");
         rts_drive_a: assert property (ce_i ##1 ce_i |=>
            rts_n[c] == !$past(modem_control_register[c][dur_pkg::DUR_MCR_RTS_BIT], 1))
            else $error("request-to-send does not follow control bit");
         stat_set_a: assert property (ce_i && events[c][dur_pkg::DUR_EV_RX_READY] |=>
            int_stat[c][dur_pkg::DUR_EV_RX_READY])
            else $error("event lost from status");
      end
   endgenerate

   // Read data latched in the setup phase, valid through the access phase
   always_comb
   begin
      next_prdata = prdata;
      if (setup)
      begin
         if (!in_map || pwrite)
            next_prdata = 32'h0000_0000;
         else
            next_prdata = rd_word[paddr[dur_pkg::DUR_CHAN_BIT]];
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n)
   begin
      if (!rst_n)
         prdata <= 32'h0000_0000;
      else if (ce_i)
         prdata <= next_prdata;
   end

   // Bus-level checks, common to both channels
   sequence rd_setup_s;
      ce_i && setup && !pwrite && in_map;
   endsequence

   sequence bad_access_s;
      ce_i && psel && penable && !in_map;
   endsequence

   sequence quiet_s;
      ce_i && !setup;
   endsequence

   rd_latch_a: assert property (rd_setup_s |=>
      prdata == $past(rd_word[paddr[dur_pkg::DUR_CHAN_BIT]]))
      else $error("read data not taken from addressed register");
   rd_hold_a: assert property (quiet_s |=> $stable(prdata))
      else $error("read data changed outside setup");
   bad_err_a: assert property (bad_access_s |-> pslverr)
      else $error("unmapped access without error response");
   bad_quiet_a: assert property (bad_access_s |=>
      $stable(modem_control_register[0]) && $stable(modem_control_register[1]) && $stable(enhanced_feature_register[0]) && $stable(enhanced_feature_register[1]))
      else $error("unmapped access changed a register");

   assign irq_o = |irq_chan;

   assign rx_ready_n_chan_a_o = rx_ready_n[0];
   assign rx_ready_n_chan_b_o = rx_ready_n[1];
   assign tx_ready_n_chan_a_o = tx_ready_n[0];
   assign tx_ready_n_chan_b_o = tx_ready_n[1];
   assign serial_out_chan_a_o = ser_out[0];
   assign serial_out_chan_b_o = ser_out[1];
   assign rx_serial_core_chan_a_o = rx_core[0];
   assign rx_serial_core_chan_b_o = rx_core[1];
   assign tx_allow_chan_a_o = tx_allow[0];
   assign tx_allow_chan_b_o = tx_allow[1];
   assign request_to_send_n_chan_a_o = rts_n[0];
   assign request_to_send_n_chan_b_o = rts_n[1];
endmodule
`default_nettype wire

// [dv/dur_far_model.sv]
// Far-end model: modem clear-to-send and receive line for both channels.
// Assumes the bench sets ready and line levels just after rising edges.
`timescale 1ns/1ps
`default_nettype none
module dur_far_model
(
   input wire logic ref_clk_i,
   input wire logic [1:0] ready_i,
   input wire logic [1:0] line_i,
   output logic [1:0] clear_to_send_n_o,
   output logic [1:0] rx_line_o
);
   // Clear-to-send low only while able to take data
   always_ff @(posedge ref_clk_i)
   begin
      clear_to_send_n_o <= ~ready_i;
      rx_line_o <= line_i;
   end
endmodule
`default_nettype wire

// [dv/test_dual_uart_host_handshake.sv]
// Self-checking bench for the two-channel UART handshake block.
// Assumes the design package, design files and far-end model come first.
`timescale 1ns/1ps
`default_nettype none
module test_dual_uart_host_handshake;
   logic clk, rst_n, ce, psel, penable, pwrite, pready, pslverr, irq, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0] rxr, txr, sout, rcore, allow, rts, cts_n, rxpin, txc, rdy, line;
   dur_pkg::dur_fifo_stat_t fifo [2];
   int error_cnt, total_checks, c, o, t;

   dur_top DUT (.ref_clk_i(clk), .reset_n_i(rst_n), .ce_i(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_o(irq),
      .fifo_chan_a_i(fifo[0]), .fifo_chan_b_i(fifo[1]),
      .clear_to_send_n_chan_a_i(cts_n[0]), .clear_to_send_n_chan_b_i(cts_n[1]),
      .rx_serial_chan_a_i(rxpin[0]), .rx_serial_chan_b_i(rxpin[1]),
      .tx_serial_core_chan_a_i(txc[0]), .tx_serial_core_chan_b_i(txc[1]),
      .rx_ready_n_chan_a_o(rxr[0]), .rx_ready_n_chan_b_o(rxr[1]),
      .tx_ready_n_chan_a_o(txr[0]), .tx_ready_n_chan_b_o(txr[1]),
      .serial_out_chan_a_o(sout[0]), .serial_out_chan_b_o(sout[1]),
      .rx_serial_core_chan_a_o(rcore[0]), .rx_serial_core_chan_b_o(rcore[1]),
      .tx_allow_chan_a_o(allow[0]), .tx_allow_chan_b_o(allow[1]),
      .request_to_send_n_chan_a_o(rts[0]), .request_to_send_n_chan_b_o(rts[1]));

   dur_far_model far (.ref_clk_i(clk), .ready_i(rdy), .line_i(line),
      .clear_to_send_n_o(cts_n), .rx_line_o(rxpin));

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   function automatic logic [11:0] ad(input int ch, input logic [2:0] i);
      return {6'h00, ch[0], i, 2'h0};
   endfunction

   // One APB transfer; read data and error taken at the pready edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("[FAIL] %s exp %0h got %0h", n, e, g);
      end
   endtask

   task tick;
      repeat (3) @(posedge clk);
   endtask

   task report_and_stop;
      if (error_cnt == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      report_and_stop;
   end

   initial
   begin
      rst_n = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      fifo[0] = '0;
      fifo[1] = '0;
      txc = 2'h3;
      rdy = 2'h0;
      line = 2'h3;
      error_cnt = 0;
      total_checks = 0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk("irq_rst", 0, irq);
      for (c = 0; c < 2; c++)
      begin
         chk("rts_rst", 1, rts[c]);
         chk("rxr_rst", 1, rxr[c]);
         apb(0, ad(c, dur_pkg::DUR_IDX_RX_TRIG), 0);
         chk("rx_trig_rst", 32'h1, rd);
         apb(0, ad(c, dur_pkg::DUR_IDX_TX_TRIG), 0);
         chk("tx_trig_rst", 32'h1, rd);
         apb(0, ad(c, dur_pkg::DUR_IDX_EFR), 0);
         chk("efr_rst", 32'h0, rd);
         apb(0, ad(c, dur_pkg::DUR_IDX_MCR), 0);
         chk("mcr_rst", 32'h0, rd);
      end
      apb(0, 12'h040, 0);
      chk("unmapped_err", 1, err);
      chk("unmapped_rd", 0, rd);
      chk("pready", 1, pready);
      ce <= 1'b0;
      fifo[0].rx_count <= 7'h01;
      tick;
      chk("rxr_frozen", 1, rxr[0]);
      ce <= 1'b1;
      tick;
      chk("rxr_thawed", 0, rxr[0]);
      fifo[0] <= '0;
      tick;
      for (c = 0; c < 2; c++)
      begin
         o = 1 - c;
         t = 4 + c;
         apb(1, ad(c, dur_pkg::DUR_IDX_RX_TRIG), t);
         apb(0, ad(o, dur_pkg::DUR_IDX_RX_TRIG), 0);
         chk("other_trig", c ? 4 : 1, rd);
         fifo[c].rx_count <= t - 1;
         tick;
         chk("rxr_below", 1, rxr[c]);
         fifo[c].rx_count <= t;
         tick;
         chk("rxr_trig", 0, rxr[c]);
         chk("rxr_other", 1, rxr[o]);
         fifo[c].rx_count <= 0;
         tick;
         chk("rxr_empty", 1, rxr[c]);
         fifo[c].rx_count <= 1;
         fifo[c].rx_timeout <= 1'b1;
         tick;
         chk("rxr_tmo", 0, rxr[c]);
         fifo[c].rx_error <= 1'b1;
         tick;
         chk("rxr_err", 1, rxr[c]);
         fifo[c] <= '0;
         apb(1, ad(c, dur_pkg::DUR_IDX_TX_TRIG), 5);
         fifo[c].tx_free <= 4;
         tick;
         chk("txr_below", 1, txr[c]);
         fifo[c].tx_free <= 5;
         tick;
         chk("txr_trig", 0, txr[c]);
         chk("txr_other", 1, txr[o]);
         fifo[c].tx_full <= 1'b1;
         tick;
         chk("txr_full", 1, txr[c]);
         fifo[c] <= '0;
         rdy[c] <= 1'b1;
         tick;
         apb(0, ad(c, dur_pkg::DUR_IDX_MSR), 0);
         chk("msr_cts_on", 32'h10, rd & 32'h10);
         rdy[c] <= 1'b0;
         tick;
         apb(0, ad(c, dur_pkg::DUR_IDX_MSR), 0);
         chk("msr_cts_off", 0, rd & 32'h10);
         chk("allow_manual", 1, allow[c]);
         apb(1, ad(c, dur_pkg::DUR_IDX_EFR), 32'h80);
         tick;
         chk("allow_auto_off", 0, allow[c]);
         chk("allow_other", 1, allow[o]);
         rdy[c] <= 1'b1;
         tick;
         chk("allow_auto_on", 1, allow[c]);
         rdy[c] <= 1'b0;
         apb(1, ad(c, dur_pkg::DUR_IDX_EFR), 0);
         apb(1, ad(c, dur_pkg::DUR_IDX_MCR), 32'h02);
         tick;
         chk("rts_on", 0, rts[c]);
         chk("rts_other", 1, rts[o]);
         txc[c] <= 1'b0;
         tick;
         chk("sout_norm", 0, sout[c]);
         chk("rcore_norm", 1, rcore[c]);
         line[c] <= 1'b0;
         tick;
         chk("rcore_pin", 0, rcore[c]);
         apb(1, ad(c, dur_pkg::DUR_IDX_MCR), 32'h10);
         tick;
         chk("sout_loop", 1, sout[c]);
         chk("rcore_loop", 0, rcore[c]);
         chk("rts_off", 1, rts[c]);
         txc[c] <= 1'b1;
         tick;
         chk("rcore_loop1", 1, rcore[c]);
         line[c] <= 1'b1;
         apb(1, ad(c, dur_pkg::DUR_IDX_MCR), 0);
         apb(1, ad(c, dur_pkg::DUR_IDX_INT_STAT), 32'hF);
         fifo[c].rx_count <= t;
         tick;
         chk("irq_masked", 0, irq);
         apb(0, ad(c, dur_pkg::DUR_IDX_INT_STAT), 0);
         chk("int_stat", 32'h1, rd);
         apb(1, ad(c, dur_pkg::DUR_IDX_INT_MASK), 32'h1);
         tick;
         chk("irq_on", 1, irq);
         apb(1, ad(c, dur_pkg::DUR_IDX_INT_STAT), 32'h1);
         tick;
         chk("irq_clr", 0, irq);
         fifo[c] <= '0;
         apb(1, ad(c, dur_pkg::DUR_IDX_INT_MASK), 0);
      end
      report_and_stop;
   end
endmodule
`default_nettype wire
